// ### design/qpi_pkg.sv
package qpi_pkg;
    // ------------------------------------------------------------
    // lane layout
    // ------------------------------------------------------------
    localparam int LANE_BITS = 7;
    localparam int LANES = 4;
    localparam int PORTS = 4;
    localparam int COMP_BITS = 8;
    localparam int HSYNC_POS = 4;
    localparam int VSYNC_POS = 5;
    localparam int DE_POS = 6;
    localparam int LANE_A = 0;
    localparam int LANE_B = 1;
    localparam int LANE_C = 2;
    localparam int LANE_D = 3;
    localparam int WORD_BITS = PORTS * 3 * COMP_BITS;
    localparam int BUF_DEPTH = 2;

    // ------------------------------------------------------------
    // timing limits, in kHz, pixel clocks and lines
    // ------------------------------------------------------------
    localparam int CLK_MIN_KHZ = 60000;
    localparam int CLK_MAX_KHZ = 66000;
    localparam int LINE_MIN = 640;
    localparam int LINE_MAX = 700;
    localparam int ACTIVE_PIX = 512;
    localparam int FRAME_MIN = 1547;
    localparam int FRAME_MAX = 1628;
    localparam int ACTIVE_LINES = 1536;
    localparam int LINE_JITTER = 1;
    localparam logic [11:0] HALF_COLS = 12'h400;

    // ------------------------------------------------------------
    // link-side states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        QPI_IDLE = 3'b001,
        QPI_ACTIVE = 3'b010,
        QPI_BLANK = 3'b100
    } qpi_state_e;
endpackage

// ### design/qpi_buf2.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-entry buffer
// ------------------------------------------------------------
module qpi_buf2 #(
    parameter int WIDTH = 96
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule // qpi_buf2

// ### design/qpi_top.sv
`timescale 1ns/1ps
module qpi_top (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PIX_CLK,
    input wire logic LANE_MAP_SELECT_N,
    input wire logic [6:0] PORT_A_LANE [0:3],
    input wire logic [6:0] PORT_B_LANE [0:3],
    input wire logic [6:0] PORT_C_LANE [0:3],
    input wire logic [6:0] PORT_D_LANE [0:3],
    output logic PIX_VALID,
    input wire logic PIX_READY,
    output logic [95:0] PIX_DATA,
    output logic [11:0] PIX_COL,
    output logic [10:0] PIX_ROW,
    output logic LINE_ERR,
    output logic FRAME_ERR
);
    localparam int W = qpi_pkg::WORD_BITS;

    // ------------------------------------------------------------
    // lane decode
    // ------------------------------------------------------------
    // one colour out of its lanes; alt selects the second map
    function automatic logic [7:0] get_comp(input logic [6:0] ln [0:3], input int c,
                                            input logic alt);
        logic [5:0] hi;
        logic [1:0] lo;
        hi = 6'h00;
        lo = 2'h0;
        case (c)
            0: hi = ln[qpi_pkg::LANE_A][5:0];
            1: hi = {ln[qpi_pkg::LANE_B][4:0], ln[qpi_pkg::LANE_A][6]};
            default: hi = {ln[qpi_pkg::LANE_C][3:0], ln[qpi_pkg::LANE_B][6:5]};
        endcase
        lo = (c == 0) ? ln[qpi_pkg::LANE_D][1:0] :
             (c == 1) ? ln[qpi_pkg::LANE_D][3:2] : ln[qpi_pkg::LANE_D][5:4];
        // D6 ignored
        get_comp = alt ? {lo, hi} : {hi, lo};
    endfunction

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    logic [6:0] lanes [0:3][0:3];
    logic sel_m1;
    logic sel_m2;
    logic map_alt;
    logic map_taken;
    logic [1:0] sel_age;
    logic [95:0] word;
    logic vs;
    logic de;
    logic de_q;
    logic vs_q;
    logic [9:0] pix_cnt;
    logic [9:0] line_len;
    logic [9:0] last_len;
    logic [10:0] act_lines;
    logic [11:0] frame_lines;
    logic [11:0] col;
    logic [10:0] row;
    logic line_err_l;
    logic frame_err_l;
    logic buf_in_ready;
    qpi_pkg::qpi_state_e state;
    qpi_pkg::qpi_state_e next_state;

    always_comb begin
        lanes[0] = PORT_A_LANE;
        lanes[1] = PORT_B_LANE;
        lanes[2] = PORT_C_LANE;
        lanes[3] = PORT_D_LANE;
    end

    // the frame timing is taken from port A only
    assign vs = PORT_A_LANE[qpi_pkg::LANE_C][qpi_pkg::VSYNC_POS];
    assign de = PORT_A_LANE[qpi_pkg::LANE_C][qpi_pkg::DE_POS];

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_port
            // ports A..D hold pixels col, col+1, col+1024, col+1025
            assign word[p*24 +: 24] = {get_comp(lanes[p], 0, map_alt),
                                       get_comp(lanes[p], 1, map_alt),
                                       get_comp(lanes[p], 2, map_alt)};
        end
    endgenerate

    // map select is a strap: synchronised then caught once
    always_ff @(posedge PIX_CLK or posedge RST) begin
        if (RST) begin
            sel_m1 <= 1'b0;
            sel_m2 <= 1'b0;
            map_alt <= 1'b0;
            map_taken <= 1'b0;
            sel_age <= 2'h0;
        end else begin
            sel_m1 <= LANE_MAP_SELECT_N;
            sel_m2 <= sel_m1;
            // wait until the synchroniser holds the pin, not its reset value
            if (!map_taken) begin
                if (sel_age == 2'h2) begin
                    map_alt <= ~sel_m2;
                    map_taken <= 1'b1;
                end else begin
                    sel_age <= sel_age + 2'h1;
                end
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            qpi_pkg::QPI_IDLE: if (vs && !vs_q) next_state = qpi_pkg::QPI_BLANK;
            qpi_pkg::QPI_BLANK: if (de) next_state = qpi_pkg::QPI_ACTIVE;
            qpi_pkg::QPI_ACTIVE: if (!de) next_state = qpi_pkg::QPI_BLANK;
            default: next_state = qpi_pkg::QPI_IDLE;
        endcase
    end

    wire line_start = de && !de_q;
    wire frame_start = vs && !vs_q;
    wire len_bad = (line_len + 10'h001 < 10'(qpi_pkg::LINE_MIN)) ||
                   (line_len + 10'h001 > 10'(qpi_pkg::LINE_MAX));
    wire jit_bad = (last_len != 10'h000) &&
                   ((line_len > last_len + 10'(qpi_pkg::LINE_JITTER)) ||
                    (line_len + 10'(qpi_pkg::LINE_JITTER) < last_len));
    wire act_bad = de_q && !de && (pix_cnt != 10'(qpi_pkg::ACTIVE_PIX));
    wire frm_bad = (frame_lines < 12'(qpi_pkg::FRAME_MIN)) ||
                   (frame_lines > 12'(qpi_pkg::FRAME_MAX)) ||
                   (act_lines != 11'(qpi_pkg::ACTIVE_LINES));

    always_ff @(posedge PIX_CLK or posedge RST) begin
        if (RST) begin
            state <= qpi_pkg::QPI_IDLE;
            de_q <= 1'b0;
            vs_q <= 1'b0;
            pix_cnt <= 10'h000;
            line_len <= 10'h000;
            last_len <= 10'h000;
            act_lines <= 11'h000;
            frame_lines <= 12'h000;
            col <= 12'h000;
            row <= 11'h000;
            line_err_l <= 1'b0;
            frame_err_l <= 1'b0;
        end else begin
            state <= next_state;
            de_q <= de;
            vs_q <= vs;
            pix_cnt <= de ? (de_q ? pix_cnt + 10'h001 : 10'h001) : pix_cnt;
            if (state != qpi_pkg::QPI_IDLE) begin
                if (line_start) begin
                    line_len <= 10'h000;
                    last_len <= line_len + 10'h001;
                    frame_lines <= frame_lines + 12'h001;
                    act_lines <= act_lines + 11'h001;
                    if (last_len != 10'h000 && (len_bad || jit_bad)) line_err_l <= ~line_err_l;
                end else begin
                    line_len <= line_len + 10'h001;
                end
                if (act_bad) line_err_l <= ~line_err_l;
            end
            if (frame_start) begin
                if (state != qpi_pkg::QPI_IDLE && frm_bad) frame_err_l <= ~frame_err_l;
                frame_lines <= 12'h000;
                act_lines <= 11'h000;
                row <= 11'h000;
            end else if (de_q && !de) begin
                row <= row + 11'h001;
            end
            col <= de ? (de_q ? col + 12'h002 : 12'h000) : col;
        end
    end

    // ------------------------------------------------------------
    // crossing: two-entry buffer on the link clock, then a handshake
    // ------------------------------------------------------------
    // words beyond what the buffer holds are dropped when the far side stalls
    logic [W+22:0] lk_word;
    logic lk_valid;
    logic lk_ready;
    logic req_t;
    logic ack_m1;
    logic ack_m2;
    logic ack_seen;
    logic req_m1;
    logic req_m2;
    logic req_seen;
    logic ack_t;
    logic [W+22:0] hold;

    qpi_buf2 #(.WIDTH(W + 23)) u_buf (
        .clk(PIX_CLK),
        .rst(RST),
        .in_valid(de && state != qpi_pkg::QPI_IDLE),
        .in_ready(buf_in_ready),
        .in_data({word, (de_q ? col + 12'h002 : 12'h000), row}),
        .out_valid(lk_valid),
        .out_ready(lk_ready),
        .out_data(lk_word)
    );
    assign lk_ready = lk_valid && (req_t == ack_m2);
    always_ff @(posedge PIX_CLK or posedge RST) begin
        if (RST) begin
            req_t <= 1'b0;
            ack_m1 <= 1'b0;
            ack_m2 <= 1'b0;
            hold <= '0;
        end else begin
            ack_m1 <= ack_t;
            ack_m2 <= ack_m1;
            if (lk_ready) begin
                hold <= lk_word;
                req_t <= ~req_t;
            end
        end
    end

    // ------------------------------------------------------------
    // reference domain
    // ------------------------------------------------------------
    logic le_m1;
    logic le_m2;
    logic fe_m1;
    logic fe_m2;
    wire fresh = (req_m2 != req_seen);
    assign PIX_VALID = fresh;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            req_m1 <= 1'b0;
            req_m2 <= 1'b0;
            req_seen <= 1'b0;
            ack_t <= 1'b0;
            PIX_DATA <= 96'h0;
            PIX_COL <= 12'h000;
            PIX_ROW <= 11'h000;
            le_m1 <= 1'b0;
            le_m2 <= 1'b0;
            fe_m1 <= 1'b0;
            fe_m2 <= 1'b0;
        end else begin
            req_m1 <= req_t;
            req_m2 <= req_m1;
            le_m1 <= line_err_l;
            le_m2 <= le_m1;
            fe_m1 <= frame_err_l;
            fe_m2 <= fe_m1;
            if (!fresh || PIX_READY) begin
                {PIX_DATA, PIX_COL, PIX_ROW} <= hold;
            end
            if (fresh && PIX_READY) begin
                req_seen <= req_m2;
                ack_t <= req_m2;
            end
        end
    end
    assign LINE_ERR = le_m2;
    assign FRAME_ERR = fe_m2;
endmodule // qpi_top

// ### tb/qpi_monitor.sv
`timescale 1ns/1ps
module qpi_monitor (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PIX_VALID,
    input wire logic PIX_READY,
    input wire logic [95:0] PIX_DATA,
    input wire logic [11:0] PIX_COL,
    input wire logic [10:0] PIX_ROW
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // consumer side of the word handshake
    // ------------------------------------------------------------
    a_valid_holds: assert property (PIX_VALID && !PIX_READY |=> PIX_VALID)
        else $error("word withdrawn before it was taken");
    a_data_stable: assert property (PIX_VALID && !PIX_READY |=> $stable(PIX_DATA))
        else $error("pixel word changed while stalled");
    a_pos_stable: assert property (PIX_VALID && !PIX_READY |=> $stable({PIX_COL, PIX_ROW}))
        else $error("pixel position changed while stalled");
    a_col_even: assert property (PIX_VALID |-> !PIX_COL[0])
        else $error("port a column is odd");
    a_col_left: assert property (PIX_VALID |-> PIX_COL < 12'h400)
        else $error("port a column outside left half");
    a_row_range: assert property (PIX_VALID |-> PIX_ROW <= 11'h5ff)
        else $error("row beyond last active row");
    a_reset_quiet: assert property (disable iff (1'b0) RST |-> !PIX_VALID && PIX_DATA == 96'h0)
        else $error("outputs not cleared in reset");
    // no word can have crossed this soon after release
    a_quiet_start: assert property ($fell(RST) |-> !PIX_VALID [*2])
        else $error("word offered right after reset");
endmodule // qpi_monitor

bind qpi_top qpi_monitor u_mon (.REF_CLK(REF_CLK), .RST(RST), .PIX_VALID(PIX_VALID),
    .PIX_READY(PIX_READY), .PIX_DATA(PIX_DATA), .PIX_COL(PIX_COL), .PIX_ROW(PIX_ROW));

// ### tb/qpi_host_model.sv
`timescale 1ns/1ps
module qpi_host_model (
    input wire logic run,
    input wire logic second_map,
    output logic pix_clk,
    output logic [6:0] lane_a [0:3],
    output logic [6:0] lane_b [0:3],
    output logic [6:0] lane_c [0:3],
    output logic [6:0] lane_d [0:3]
);
    logic spare = 1'b0;
    initial begin
        pix_clk = 1'b0;
        lane_a = '{default: 7'h0};
        lane_b = '{default: 7'h0};
        lane_c = '{default: 7'h0};
        lane_d = '{default: 7'h0};
        #3;
        forever begin
            // nothing in the logic measures the rate, so the bench runs it fast
            #6;
            pix_clk = run ? ~pix_clk : 1'b0;
        end
    end
    // ------------------------------------------------------------
    // one port's lanes, packed {d, c, b, a}
    // ------------------------------------------------------------
    function automatic logic [27:0] enc(input logic [23:0] c, input logic m,
                                        input logic [2:0] sync, input logic d6);
        logic [5:0] rh, gh, bh;
        logic [1:0] rl, gl, bl;
        rh = m ? c[21:16] : c[23:18];
        gh = m ? c[13:8] : c[15:10];
        bh = m ? c[5:0] : c[7:2];
        {rl, gl, bl} = m ? {c[23:22], c[15:14], c[7:6]} : {c[17:16], c[9:8], c[1:0]};
        return {d6, bl, gl, rl, sync, bh, gh, rh};
    endfunction
    // sync is {de, vsync, hsync}, same on every port
    task automatic send(input logic [95:0] w, input logic [2:0] sync);
        logic [27:0] p [0:3];
        @(posedge pix_clk);
        spare = ~spare;
        // port A sits in the low 24 bits of the word, port D in the top
        for (int i = 0; i < 4; i++) p[i] = enc(w[24*i +: 24], second_map, sync, spare);
        lane_a <= '{p[0][6:0], p[0][13:7], p[0][20:14], p[0][27:21]};
        lane_b <= '{p[1][6:0], p[1][13:7], p[1][20:14], p[1][27:21]};
        lane_c <= '{p[2][6:0], p[2][13:7], p[2][20:14], p[2][27:21]};
        lane_d <= '{p[3][6:0], p[3][13:7], p[3][20:14], p[3][27:21]};
    endtask
    // idle cycles carry the inverse so a held value cannot pass for data
    // one-clock lines break on purpose, so the fault flags move
    task automatic pixel(input logic [95:0] w);
        send(w, 3'h4);
        repeat (7) send(~w, 3'h0);
    endtask
    task automatic frame();
        repeat (2) send(96'h0, 3'h2);
        repeat (2) send(96'h0, 3'h0);
    endtask
endmodule // qpi_host_model

// ### tb/tb_quad_port_pixel_input.sv
`timescale 1ns/1ps
module tb_quad_port_pixel_input;
    typedef struct packed {logic [95:0] word; logic [95:0] exp;} qpi_row_s;
    logic ref_clk, rst, run, map_n, pix_ready, pix_valid, pix_clk;
    logic line_err, frame_err;
    logic [95:0] pix_data;
    logic [11:0] pix_col;
    logic [10:0] pix_row;
    logic [6:0] lane_a [0:3];
    logic [6:0] lane_b [0:3];
    logic [6:0] lane_c [0:3];
    logic [6:0] lane_d [0:3];
    int fails = 0;
    int n_tests = 0;
    qpi_row_s rows [0:5] = '{
        '{96'h0, 96'h0},
        '{{4{24'hffffff}}, {4{24'hffffff}}},
        '{{4{24'hff0000}}, {4{24'hff0000}}},
        '{{4{24'h00ff00}}, {4{24'h00ff00}}},
        '{{4{24'h0000ff}}, {4{24'h0000ff}}},
        '{96'h80c1e2013f7ea55a3cfe017f, 96'h80c1e2013f7ea55a3cfe017f}};

    qpi_top u_dut (.REF_CLK(ref_clk), .RST(rst), .PIX_CLK(pix_clk), .LANE_MAP_SELECT_N(map_n),
        .PORT_A_LANE(lane_a), .PORT_B_LANE(lane_b), .PORT_C_LANE(lane_c), .PORT_D_LANE(lane_d),
        .PIX_VALID(pix_valid), .PIX_READY(pix_ready), .PIX_DATA(pix_data), .PIX_COL(pix_col),
        .PIX_ROW(pix_row), .LINE_ERR(line_err), .FRAME_ERR(frame_err));
    qpi_host_model u_host (.run(run), .second_map(!map_n), .pix_clk(pix_clk),
        .lane_a(lane_a), .lane_b(lane_b), .lane_c(lane_c), .lane_d(lane_d));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // checking and handshake
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // each pixel is its own one-clock line, so its row is its order
    task automatic take(input logic [95:0] exp, input int row);
        for (int k = 0; k < 60; k++) begin
            @(negedge ref_clk);
            if (pix_valid === 1'b1) break;
        end
        check("pix_valid", 96'h1, {95'h0, pix_valid});
        if (pix_valid !== 1'b1) wrap_up();
        check("pix_data", exp, pix_data);
        check("pix_col", 96'h0, {84'h0, pix_col});
        check("pix_row", 96'(row), {85'h0, pix_row});
        @(posedge ref_clk) pix_ready <= 1'b1;
        @(posedge ref_clk) pix_ready <= 1'b0;
    endtask
    task automatic do_reset(input logic sel_n);
        @(posedge ref_clk) rst <= 1'b1;
        map_n <= sel_n;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk) check("reset pix_data", 96'h0, pix_data);
        check("reset line_err", 96'h0, {95'h0, line_err});
        check("reset frame_err", 96'h0, {95'h0, frame_err});
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        u_host.frame();
    endtask
    task automatic run_rows();
        foreach (rows[i]) begin
            u_host.pixel(rows[i].word);
            take(rows[i].exp, i);
            // the first line has no earlier line to measure, only its short enable
            if (i == 0) check("line_err", 96'h1, {95'h0, line_err});
        end
    endtask

    initial begin
        rst = 1'b1;
        run = 1'b1;
        map_n = 1'b1;
        pix_ready = 1'b0;
        do_reset(1'b1);
        run_rows();
        // two words land while the consumer stalls; both survive in order
        u_host.pixel(rows[5].word);
        u_host.pixel(rows[1].word);
        take(rows[5].exp, 6);
        take(rows[1].exp, 7);
        repeat (20) @(negedge ref_clk);
        check("drained pix_valid", 96'h0, {95'h0, pix_valid});
        // a frame of a few lines is flagged when the next frame begins
        u_host.frame();
        repeat (4) @(negedge ref_clk);
        check("frame_err", 96'h1, {95'h0, frame_err});
        // strap low picks the second map after a fresh reset
        do_reset(1'b0);
        run_rows();
        wrap_up();
    end
endmodule // tb_quad_port_pixel_input
